// ### port_c_pkg.sv
// Constants, register map and pin-mux types of the 8-bit port with serial sharing
package port_c_pkg;

    // ------------------------------------------------------------------
    // Register map on the plain register port
    // ------------------------------------------------------------------
    localparam int          ADDR_W          = 3;
    localparam logic [2:0]  ADDR_OUT_LATCH  = 3'h0;
    localparam logic [2:0]  ADDR_PIN_STATE  = 3'h1;
    localparam logic [2:0]  ADDR_PULLUP     = 3'h2;
    localparam logic [2:0]  ADDR_OPEN_DRAIN = 3'h3;
    localparam logic [2:0]  ADDR_DIRECTION  = 3'h4;

    // ------------------------------------------------------------------
    // Reset values and widths
    // ------------------------------------------------------------------
    localparam int          PORT_W          = 8;
    localparam int          CH_N            = 2;
    localparam logic [7:0]  OUT_LATCH_RST   = 8'h00;
    localparam logic [7:0]  PULLUP_RST      = 8'h00;
    localparam logic [7:0]  OPEN_DRAIN_RST  = 8'h00;
    localparam logic [7:0]  DIRECTION_RST   = 8'h00;
    localparam logic [7:0]  READ_NONE       = 8'h00;
    localparam logic [1:0]  SYNC_RST        = 2'h0;

    // ------------------------------------------------------------------
    // Pin positions: channel n uses pins 3n (tx), 3n+1 (rx), 3n+2 (clock)
    // ------------------------------------------------------------------
    localparam int          CH_STRIDE       = 3;
    localparam int          PIN_TX_OFS      = 0;
    localparam int          PIN_RX_OFS      = 1;
    localparam int          PIN_CLK_OFS     = 2;
    localparam int          PIN_EXT_B       = 2;
    localparam int          PIN_EXT_A       = 5;

    // ------------------------------------------------------------------
    // Clock pin modes, gray coded along gpio -> output -> input
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CLK_GPIO = 2'h0,
        CLK_OUT  = 2'h1,
        CLK_IN   = 2'h3
    } clk_mode_t;

    // Clock pin selection from the channel's clock source and sync bits
    function automatic clk_mode_t clk_pin_mode(input logic src_bit1,
                                               input logic src_bit0,
                                               input logic sync_sel);
        clk_pin_mode = CLK_GPIO;
        if (src_bit1) begin
            clk_pin_mode = CLK_IN;
        end else if (sync_sel || src_bit0) begin
            clk_pin_mode = CLK_OUT;
        end
    endfunction : clk_pin_mode

endpackage : port_c_pkg

// ### port_c_sync.sv
// Two-stage level synchroniser for the port's pad inputs
`timescale 1ns/1ps
`default_nettype none

module port_c_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             clock_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_state_t;

    sync_state_t st;
    sync_state_t next_st;

    // First stage feeds only the second stage
    always_comb begin
        next_st        = st;
        next_st.stage1 = d_i;
        next_st.stage2 = st.stage1;
    end

    // State register, cleared synchronously
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q_o = st.stage2;

endmodule : port_c_sync

`default_nettype wire

// ### port_c_gpio.sv
// Top of the 8-bit general-purpose port with serial and interrupt pin sharing
//
// Function
// - Eight-bit output latch, reset 0, drives pins selected as general outputs.
// - Pin-state read returns the latch bit where direction is 1.
// - Pin-state read returns the sampled pad level where direction is 0.
// - Pin-state register is read-only; writes change nothing.
// - Pull-up output on for general input pins whose pull-up bit is 1.
// - Open-drain bit 1 turns off high drive on general outputs; resets 0.
// - Two upper pins are plain general input or output by direction.
// - Serial functions take shared pins over the direction bit; interrupt inputs only sample them.
// - Channel 1 clock pin: input, output or general by source and sync bits.
// - Channel 0 clock pin selects alike; in general mode feeds ext_b.
// - Receive pin is serial input when rx_on, else general by direction.
// - Transmit pin is driven by transmitter when tx_on, else general.
// - Direction register write-only, resets 0; 1 is output, read undefined.
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none

module port_c_gpio (
    input  wire logic                          clock_i,
    input  wire logic                          rst_i,
    input  wire logic [port_c_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [7:0]                    wdata_i,
    input  wire logic                          wr_i,
    input  wire logic                          rd_i,
    output logic      [7:0]                    rdata_o,
    input  wire logic [7:0]                    pin_i,
    output logic      [7:0]                    pin_o,
    output logic      [7:0]                    pin_oe_o,
    output logic      [7:0]                    pullup_o,
    input  wire logic [1:0]                    clk_src_bit1_i,
    input  wire logic [1:0]                    clk_src_bit0_i,
    input  wire logic [1:0]                    sync_sel_i,
    input  wire logic [1:0]                    rx_on_i,
    input  wire logic [1:0]                    tx_on_i,
    input  wire logic [1:0]                    ser_clk_drv_i,
    input  wire logic [1:0]                    ser_tx_i,
    output logic      [1:0]                    ser_clk_o,
    output logic      [1:0]                    ser_rx_o,
    output logic                               ext_a_o,
    output logic                               ext_b_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] out_latch;
        logic [7:0] direction_bits;
        logic [7:0] pullup_bits;
        logic [7:0] opendrain_bits;
        logic [7:0] rd_data;
        logic [7:0] pin_out;
        logic [7:0] pin_oe;
        logic [7:0] pull;
        logic [1:0] ser_clk;
        logic [1:0] ser_rx;
        logic       ext_a;
        logic       ext_b;
    } port_state_t;

    localparam port_state_t RESET_STATE = '{
        out_latch:      port_c_pkg::OUT_LATCH_RST,
        direction_bits: port_c_pkg::DIRECTION_RST,
        pullup_bits:    port_c_pkg::PULLUP_RST,
        opendrain_bits: port_c_pkg::OPEN_DRAIN_RST,
        rd_data:        port_c_pkg::READ_NONE,
        pin_out:        8'h00,
        pin_oe:         8'h00,
        pull:           8'h00,
        ser_clk:        port_c_pkg::SYNC_RST,
        ser_rx:         port_c_pkg::SYNC_RST,
        ext_a:          1'b0,
        ext_b:          1'b0
    };

    port_state_t st;
    port_state_t next_st;
    logic [7:0]  pin_sync;
    logic [7:0]  pin_state;

    // ------------------------------------------------------------------
    // Pad input synchroniser
    // ------------------------------------------------------------------
    port_c_sync #(
        .WIDTH (8)
    ) u_sync (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .d_i     (pin_i),
        .q_o     (pin_sync)
    );

    // Pin-state view: latch where output, synchronised pad where input
    assign pin_state = (st.out_latch & st.direction_bits)
                     | (pin_sync & ~st.direction_bits);

    // ------------------------------------------------------------------
    // Register port, pin multiplexer and function inputs
    // ------------------------------------------------------------------
    always_comb begin
        port_c_pkg::clk_mode_t mode;
        logic [7:0]            take;
        logic [7:0]            fn_out;
        logic [7:0]            fn_oe;
        mode    = port_c_pkg::CLK_GPIO;
        take    = 8'h00;
        fn_out  = 8'h00;
        fn_oe   = 8'h00;
        next_st = st;
        next_st.rd_data = port_c_pkg::READ_NONE;

        // Register writes; pin-state and unmapped addresses ignore them
        if (wr_i) begin
            case (addr_i)
                port_c_pkg::ADDR_OUT_LATCH:  next_st.out_latch      = wdata_i;
                port_c_pkg::ADDR_PULLUP:     next_st.pullup_bits    = wdata_i;
                port_c_pkg::ADDR_OPEN_DRAIN: next_st.opendrain_bits = wdata_i;
                port_c_pkg::ADDR_DIRECTION:  next_st.direction_bits = wdata_i;
                default: ;
            endcase
        end

        // Register reads, data valid in the following cycle only
        if (rd_i) begin
            case (addr_i)
                port_c_pkg::ADDR_OUT_LATCH:  next_st.rd_data = st.out_latch;
                port_c_pkg::ADDR_PIN_STATE:  next_st.rd_data = pin_state;
                port_c_pkg::ADDR_PULLUP:     next_st.rd_data = st.pullup_bits;
                port_c_pkg::ADDR_OPEN_DRAIN: next_st.rd_data = st.opendrain_bits;
                default:                     next_st.rd_data = port_c_pkg::READ_NONE;
            endcase
        end

        // Serial channel selection per channel
        next_st.ext_a = 1'b0;
        next_st.ext_b = 1'b0;
        for (int ch = 0; ch < port_c_pkg::CH_N; ch++) begin
            mode = port_c_pkg::clk_pin_mode(clk_src_bit1_i[ch],
                                            clk_src_bit0_i[ch],
                                            sync_sel_i[ch]);
            // Clock pin
            case (mode)
                port_c_pkg::CLK_IN: begin
                    take[ch*port_c_pkg::CH_STRIDE + port_c_pkg::PIN_CLK_OFS] = 1'b1;
                end
                port_c_pkg::CLK_OUT: begin
                    take[ch*port_c_pkg::CH_STRIDE + port_c_pkg::PIN_CLK_OFS]   = 1'b1;
                    fn_oe[ch*port_c_pkg::CH_STRIDE + port_c_pkg::PIN_CLK_OFS]  = 1'b1;
                    fn_out[ch*port_c_pkg::CH_STRIDE + port_c_pkg::PIN_CLK_OFS] =
                        ser_clk_drv_i[ch];
                end
                default: ;
            endcase
            next_st.ser_clk[ch] = (mode == port_c_pkg::CLK_IN)
                ? pin_sync[ch*port_c_pkg::CH_STRIDE + port_c_pkg::PIN_CLK_OFS] : 1'b0;
            // Interrupt inputs see the clock pin only in general mode
            if (mode == port_c_pkg::CLK_GPIO) begin
                if (ch == 0) begin
                    next_st.ext_b = pin_sync[port_c_pkg::PIN_EXT_B];
                end else begin
                    next_st.ext_a = pin_sync[port_c_pkg::PIN_EXT_A];
                end
            end
            // Receive pin
            if (rx_on_i[ch]) begin
                take[ch*port_c_pkg::CH_STRIDE + port_c_pkg::PIN_RX_OFS] = 1'b1;
            end
            next_st.ser_rx[ch] = rx_on_i[ch]
                ? pin_sync[ch*port_c_pkg::CH_STRIDE + port_c_pkg::PIN_RX_OFS] : 1'b0;
            // Transmit pin
            if (tx_on_i[ch]) begin
                take[ch*port_c_pkg::CH_STRIDE + port_c_pkg::PIN_TX_OFS]   = 1'b1;
                fn_oe[ch*port_c_pkg::CH_STRIDE + port_c_pkg::PIN_TX_OFS]  = 1'b1;
                fn_out[ch*port_c_pkg::CH_STRIDE + port_c_pkg::PIN_TX_OFS] = ser_tx_i[ch];
            end
        end

        // Pin drivers from the values that take effect this edge
        for (int p = 0; p < port_c_pkg::PORT_W; p++) begin
            if (take[p]) begin
                next_st.pin_out[p] = fn_out[p];
                next_st.pin_oe[p]  = fn_oe[p];
                next_st.pull[p]    = 1'b0;
            end else begin
                next_st.pin_out[p] = next_st.out_latch[p];
                next_st.pin_oe[p]  = next_st.direction_bits[p]
                    & ~(next_st.opendrain_bits[p] & next_st.out_latch[p]);
                next_st.pull[p]    = ~next_st.direction_bits[p]
                    & next_st.pullup_bits[p];
            end
        end
    end

    // State register, synchronous reset
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st <= RESET_STATE;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign rdata_o   = st.rd_data;
    assign pin_o     = st.pin_out;
    assign pin_oe_o  = st.pin_oe;
    assign pullup_o  = st.pull;
    assign ser_clk_o = st.ser_clk;
    assign ser_rx_o  = st.ser_rx;
    assign ext_a_o   = st.ext_a;
    assign ext_b_o   = st.ext_b;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_latch_reset_zero: assert property (
        @(posedge clock_i) rst_i |=> (st.out_latch == 8'h00 && pin_oe_o == 8'h00))
        else $error("output latch not cleared by reset");

    chk_read_out_bits: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (rd_i && addr_i == port_c_pkg::ADDR_PIN_STATE) |=>
        (((rdata_o ^ $past(st.out_latch)) & $past(st.direction_bits)) == 8'h00))
        else $error("pin-state read did not return latch for output bits");

    chk_read_pad_bits: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (!$past(rst_i) && !$past(rst_i, 2) && rd_i && addr_i == port_c_pkg::ADDR_PIN_STATE) |=>
        (((rdata_o ^ $past(pin_i, 3)) & ~$past(st.direction_bits)) == 8'h00))
        else $error("pin-state read did not return pad level for input bits");

    chk_pin_state_ro: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (wr_i && addr_i == port_c_pkg::ADDR_PIN_STATE) |=>
        ($stable(st.out_latch) && $stable(st.direction_bits) && $stable(pin_o)))
        else $error("write to pin-state register changed state");

    chk_pullup_upper: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (wr_i && addr_i == port_c_pkg::ADDR_PULLUP && !st.direction_bits[7]) |=>
        (pullup_o[7] == $past(wdata_i[7])))
        else $error("pull-up output did not follow pull-up bit");

    chk_open_drain_high: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (wr_i && addr_i == port_c_pkg::ADDR_OUT_LATCH && wdata_i[6]
         && st.direction_bits[6] && st.opendrain_bits[6]) |=> !pin_oe_o[6])
        else $error("open-drain pin drove high");

    chk_upper_output: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (wr_i && addr_i == port_c_pkg::ADDR_DIRECTION && wdata_i[7]
         && !st.opendrain_bits[7]) |=> (pin_oe_o[7] && pin_o[7] == st.out_latch[7]))
        else $error("upper pin did not become an output");

    chk_clk_in_mode: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (!rst_i && clk_src_bit1_i[1]) |=> !pin_oe_o[5])
        else $error("channel 1 clock input pin driven");

    chk_clk_out_mode: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (!rst_i && !clk_src_bit1_i[1] && (sync_sel_i[1] || clk_src_bit0_i[1])) |=>
        (pin_oe_o[5] && pin_o[5] == $past(ser_clk_drv_i[1]) && !ext_a_o))
        else $error("channel 1 clock output pin wrong");

    chk_ext_b_feed: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (!$past(rst_i) && !$past(rst_i, 2)
         && !clk_src_bit1_i[0] && !clk_src_bit0_i[0] && !sync_sel_i[0]) |=>
        (ext_b_o == $past(pin_i[2], 3)))
        else $error("ext_b does not follow channel 0 clock pin");

    chk_rx_take: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (!$past(rst_i) && !$past(rst_i, 2) && rx_on_i[0]) |=>
        (!pin_oe_o[1] && ser_rx_o[0] == $past(pin_i[1], 3)))
        else $error("receive pin not handed to channel 0");

    chk_tx_drive: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (!rst_i && tx_on_i[1]) |=> (pin_oe_o[3] && pin_o[3] == $past(ser_tx_i[1])))
        else $error("transmit pin not driven by channel 1");

    chk_func_pull_off: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (!rst_i && tx_on_i[0]) |=>
        (pin_oe_o[0] && !pullup_o[0] && pin_o[0] == $past(ser_tx_i[0])))
        else $error("transmit pin 0 not taken from general drive");

    chk_ext_a_feed: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (!$past(rst_i) && !$past(rst_i, 2)
         && !clk_src_bit1_i[1] && !clk_src_bit0_i[1] && !sync_sel_i[1]) |=>
        (ext_a_o == $past(pin_i[5], 3)))
        else $error("ext_a does not follow channel 1 clock pin");

    chk_dir_write: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (wr_i && addr_i == port_c_pkg::ADDR_DIRECTION) |=>
        (st.direction_bits == $past(wdata_i)))
        else $error("direction write not taken");

endmodule : port_c_gpio

`default_nettype wire

// ### pad_model.sv
// Pad model: resolves each pin from port drive, outside driver and pull-up
`timescale 1ns/1ps
`default_nettype none

module pad_model (
    input  wire logic       clock_i,
    input  wire logic [7:0] pin_o_i,
    input  wire logic [7:0] pin_oe_i,
    input  wire logic [7:0] pullup_i,
    input  wire logic [7:0] ext_val_i,
    input  wire logic [7:0] ext_en_i,
    output logic      [7:0] pad_o
);
    logic [7:0] wander = 8'h5a;

    // ----------------------------------------
    // Pad resolution
    // ----------------------------------------
    // Undriven pads wander so a stale level never passes for a real one
    always @(posedge clock_i) begin
        wander <= ~wander;
    end

    // Port drive wins, then the outside driver, then the pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe_i[i]) pad_o[i] = pin_o_i[i];
            else if (ext_en_i[i]) pad_o[i] = ext_val_i[i];
            else if (pullup_i[i]) pad_o[i] = 1'b1;
            else pad_o[i] = wander[i];
        end
    end
endmodule : pad_model
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the 8-bit port with serial pin sharing
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic                          clock_i, rst_i, wr_i, rd_i, ext_a_o, ext_b_o;
    logic [port_c_pkg::ADDR_W-1:0] addr_i;
    logic [7:0]                    wdata_i, rdata_o, pin_i, pin_o, pin_oe_o, pullup_o;
    logic [1:0]                    src1, src0, sync_sel, rx_on, tx_on, clk_drv, ser_tx;
    logic [1:0]                    ser_clk_o, ser_rx_o, e_clk, e_rx;
    logic [7:0]                    ext_val, ext_en, seed, m, v, d, p, od;
    logic [7:0]                    e_oe, e_o, e_pu, e_pad;
    logic                          e_a, e_b;
    logic                          rd_seen = 1'b0;
    logic [7:0]                    rd_q[$];
    int                            n_errors, checks_done;

    port_c_gpio dut (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe_o(pin_oe_o), .pullup_o(pullup_o), .clk_src_bit1_i(src1),
        .clk_src_bit0_i(src0), .sync_sel_i(sync_sel), .rx_on_i(rx_on), .tx_on_i(tx_on),
        .ser_clk_drv_i(clk_drv), .ser_tx_i(ser_tx), .ser_clk_o(ser_clk_o),
        .ser_rx_o(ser_rx_o), .ext_a_o(ext_a_o), .ext_b_o(ext_b_o));

    pad_model pads (.clock_i(clock_i), .pin_o_i(pin_o), .pin_oe_i(pin_oe_o),
        .pullup_i(pullup_o), .ext_val_i(ext_val), .ext_en_i(ext_en), .pad_o(pin_i));

    // ----------------------------------------
    // Clock, watchdog, helpers
    // ----------------------------------------
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    initial begin
        #100000;
        n_errors++;
        end_of_test();
    end

    function automatic logic [7:0] rnd();
        seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
        return seed;
    endfunction : rnd

    task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp8

    // Read data stands only in the cycle after the strobe
    always @(posedge clock_i) begin
        if (rd_seen) cmp8("read data", rd_q.pop_front(), rdata_o);
        rd_seen <= rd_i;
    end

    task automatic wr(input logic [2:0] a, input logic [7:0] x);
        addr_i <= a;
        wdata_i <= x;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
        @(posedge clock_i);
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [7:0] x);
        rd_q.push_back(x);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        @(posedge clock_i);
    endtask : rd

    // Expected pin picture from bench register copies and mode inputs
    task automatic calc();
        int c;
        for (int i = 0; i < 8; i++) begin
            c = i / 3;
            e_oe[i] = d[i] & ~(od[i] & v[i]);
            e_o[i] = v[i];
            e_pu[i] = ~d[i] & p[i];
            if (i < 6) begin
                case (i % 3)
                    0: if (tx_on[c]) {e_oe[i], e_o[i], e_pu[i]} = {1'b1, ser_tx[c], 1'b0};
                    1: if (rx_on[c]) {e_oe[i], e_pu[i]} = 2'b00;
                    default: if (src1[c]) {e_oe[i], e_pu[i]} = 2'b00;
                        else if (sync_sel[c] | src0[c])
                            {e_oe[i], e_o[i], e_pu[i]} = {1'b1, clk_drv[c], 1'b0};
                endcase
            end
            e_pad[i] = e_oe[i] ? e_o[i] : ext_val[i];
        end
        e_rx = {rx_on[1] & e_pad[4], rx_on[0] & e_pad[1]};
        e_clk = {src1[1] & e_pad[5], src1[0] & e_pad[2]};
        e_a = ~(src1[1] | sync_sel[1] | src0[1]) & e_pad[5];
        e_b = ~(src1[0] | sync_sel[0] | src0[0]) & e_pad[2];
    endtask : calc

    task automatic check_all();
        calc();
        #1;
        cmp8("pin enable", e_oe, pin_oe_o);
        cmp8("pin value", e_o & e_oe, pin_o & pin_oe_o);
        cmp8("pull-up", e_pu, pullup_o);
        cmp8("clock in", {6'h0, e_clk}, {6'h0, ser_clk_o});
        cmp8("receive", {6'h0, e_rx}, {6'h0, ser_rx_o});
        cmp8("ext inputs", {6'h0, e_a, e_b}, {6'h0, ext_a_o, ext_b_o});
        @(posedge clock_i);
        rd(port_c_pkg::ADDR_PIN_STATE, (v & d) | (e_pad & ~d));
    endtask : check_all

    task automatic end_of_test();
        n_errors += rd_q.size(); // Reads never answered
        $display("Checks %0d, errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {rst_i, wr_i, rd_i, addr_i, wdata_i} = {3'b100, 3'h0, 8'h00};
        {src1, src0, sync_sel, rx_on, tx_on, clk_drv, ser_tx} = 14'h0;
        {ext_val, ext_en, seed, v, d, p, od} = {8'h00, 8'hff, 8'h15, 32'h0};
        repeat (8) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        // Reset picture and register reset values
        check_all();
        rd(port_c_pkg::ADDR_OUT_LATCH, 8'h00);
        rd(port_c_pkg::ADDR_PULLUP, 8'h00);
        rd(port_c_pkg::ADDR_OPEN_DRAIN, 8'h00);
        rd(port_c_pkg::ADDR_DIRECTION, 8'h00);
        // Latch write reaches the pins at the next edge
        d = 8'hff;
        wr(port_c_pkg::ADDR_DIRECTION, d);
        v = rnd();
        addr_i <= port_c_pkg::ADDR_OUT_LATCH;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
        #1;
        cmp8("pin value at next edge", v, pin_o);
        @(posedge clock_i);
        // Read-only and unmapped writes change nothing
        wr(port_c_pkg::ADDR_PIN_STATE, ~v);
        for (int a = 5; a < 8; a++) wr(a[2:0], rnd());
        repeat (3) @(posedge clock_i);
        check_all();
        rd(port_c_pkg::ADDR_OUT_LATCH, v);
        for (int a = 5; a < 8; a++) rd(a[2:0], 8'h00);
        // Pull-ups hold undriven inputs high
        d = 8'h00;
        p = 8'hff;
        wr(port_c_pkg::ADDR_DIRECTION, d);
        wr(port_c_pkg::ADDR_PULLUP, p);
        ext_en <= 8'h00;
        repeat (5) @(posedge clock_i);
        rd(port_c_pkg::ADDR_PIN_STATE, 8'hff);
        ext_en <= 8'hff;
        // Every clock pin mode with random registers and functions
        for (int k = 0; k < 16; k++) begin
            v = rnd();
            d = rnd();
            p = rnd();
            od = rnd();
            m = rnd();
            wr(port_c_pkg::ADDR_OUT_LATCH, v);
            wr(port_c_pkg::ADDR_DIRECTION, d);
            wr(port_c_pkg::ADDR_PULLUP, p);
            wr(port_c_pkg::ADDR_OPEN_DRAIN, od);
            rd(port_c_pkg::ADDR_OPEN_DRAIN, od);
            src1 <= {~k[2], k[2]};
            sync_sel <= {~k[1], k[1]};
            src0 <= {~k[0], k[0]};
            {rx_on, tx_on, clk_drv, ser_tx} <= m;
            ext_val <= rnd();
            repeat (5) @(posedge clock_i);
            check_all();
        end
        // Reset again in mid-run
        rst_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        rst_i <= 1'b0;
        {v, d, p, od} = 32'h0;
        repeat (4) @(posedge clock_i);
        check_all();
        rd(port_c_pkg::ADDR_PULLUP, 8'h00);
        @(posedge clock_i);
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
